// *** time_proportioning_output.sv ***
// Time-proportioning output: scales a demand and switches one output.
// Assumes demand and settings are synchronous; line_cycle_in pulses once per ac cycle.
//
// Operation
// (R1) Average on time equals requested percentage
// (R2) Fixed mode: period is one on-off cycle
// (R3) Line mode: switch at most every three cycles
// (R4) Line 66% gives 6 on 3 off
// (R5) Solid-state period 0.1 to 60.0 s
// (R6) Relay variant always uses fixed period
// (R7) Relay variant period 5.0 to 60.0 s
// (R8) Off/0% off, on/100% on continuously; code maps them to the floor and ceiling levels instead
// (R9) Zero demand maps to floor level
// (R10) Full demand maps to ceiling level
// (R11) Between: linear interpolation floor to ceiling
// (R12) Floor and ceiling 0.0 to 100.0 percent
// (R13) Solid-state outputs obey selected switching method
// (R14) Sample scaled demand at each cycle start
// (R15) Upstream holds demand stable between updates
`timescale 1ns/1ps
module time_proportioning_output
  import tpo_pkg::*;
#(
  parameter bit RELAY_VARIANT = 1'b0,
  // Clock cycles per tenth of a second; a bench may shorten it
  parameter int unsigned TICKS_PER_TENTH = TENTH_CYCLES
)
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic demand_is_digital_in,
  input wire logic demand_digital_in,
  input wire logic [6:0] demand_pct_in,
  input wire logic method_line_in,
  input wire logic [9:0] period_tenths_in,
  input wire logic [9:0] floor_permille_in,
  input wire logic [9:0] ceil_permille_in,
  input wire logic line_cycle_in,
  output logic load_on_out,
  output logic [9:0] power_permille_out,
  output logic [9:0] period_used_out
);
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ON = 2'b01,
    ST_PROP = 2'b10
  } mode_e;

  tpo_scale_if sc();

  logic [6:0] pct;
  logic [9:0] period_c;
  logic [9:0] floor_c;
  logic [9:0] ceil_c;
  method_e method;
  mode_e mode;

  logic [22:0] tick_r, tick_nxt;
  logic [9:0] tenth_r, tenth_nxt;
  logic [9:0] duty_r, duty_nxt;
  logic [9:0] period_r, period_nxt;
  logic [12:0] acc_r, acc_nxt;
  logic [1:0] run_r, run_nxt;
  logic out_r, out_nxt;
  logic line_on_r, line_on_nxt;
  logic [31:0] on_ticks;
  logic [31:0] elapsed;
  logic [12:0] acc_add;
  logic want_on;
  logic tenth_done;
  logic period_done;
  logic run_end;

  // Refuse timebases the tick counter or the position word cannot hold
  if (TICKS_PER_TENTH < 1 || TICKS_PER_TENTH > 32'h007FFFFF) begin : g_ticks_bad
    $error("TICKS_PER_TENTH must be 1 to 8388607");
  end
  if (64'(PERIOD_MAX) * 64'(TICKS_PER_TENTH) > 64'h00000000FFFFFFFF) begin : g_span_bad
    $error("Longest period overflows the 32-bit position");
  end
  // The run counter is two bits wide and needs a nonzero run length
  if (LINE_MIN_RUN == 2'h0) begin : g_run_bad
    $error("LINE_MIN_RUN must be nonzero");
  end
  if (PERIOD_MIN_RELAY > PERIOD_MAX || PERIOD_RESET > PERIOD_MAX) begin : g_limits_bad
    $error("Period limits are inconsistent");
  end

  always_comb begin
    // Clamp settings to their legal ranges
    floor_c = (floor_permille_in > PERMILLE_FULL) ? PERMILLE_FULL : floor_permille_in; // (R12)
    ceil_c = (ceil_permille_in > PERMILLE_FULL) ? PERMILLE_FULL : ceil_permille_in; // (R12)
    period_c = period_tenths_in;
    if (RELAY_VARIANT && period_c < PERIOD_MIN_RELAY) begin
      period_c = PERIOD_MIN_RELAY; // (R7)
    end else if (period_c < PERIOD_MIN_SSR) begin
      period_c = PERIOD_MIN_SSR; // (R5)
    end
    if (period_c > PERIOD_MAX) begin
      period_c = PERIOD_MAX; // (R5) (R7)
    end
  end

  always_comb begin
    method = (RELAY_VARIANT || !method_line_in) ? METHOD_FIXED : METHOD_LINE; // (R6) (R13)
  end

  always_comb begin
    // Digital demand stands in as 0 or 100 percent
    if (demand_is_digital_in) begin
      pct = demand_digital_in ? DEMAND_FULL : 7'h00;
    end else begin
      pct = (demand_pct_in > DEMAND_FULL) ? DEMAND_FULL : demand_pct_in; // (R15)
    end
  end

  assign sc.demand = pct;
  assign sc.floor_pm = floor_c;
  assign sc.ceil_pm = ceil_c;

  tpo_scaler u_scaler (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .sc(sc)
  );

  always_comb begin
    // Scaled power decides continuous states as well
    if (sc.power_pm == 10'h000) begin
      mode = ST_OFF; // (R8)
    end else if (sc.power_pm >= PERMILLE_FULL) begin
      mode = ST_ON; // (R8)
    end else begin
      mode = ST_PROP;
    end
  end

  // Fixed period timebase in tenths of a second
  assign tenth_done = (tick_r == 23'(TICKS_PER_TENTH - 1));
  assign period_done = tenth_done && (tenth_r >= period_r - 10'h001);

  always_comb begin
    tick_nxt = tick_r + 23'h000001;
    if (tenth_done) begin
      tick_nxt = 23'h000000;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_r <= 23'h000000;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  always_comb begin
    tenth_nxt = tenth_r;
    if (period_done) begin
      tenth_nxt = 10'h000;
    end else if (tenth_done) begin
      tenth_nxt = tenth_r + 10'h001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tenth_r <= 10'h000;
    end else begin
      tenth_r <= tenth_nxt;
    end
  end

  // New cycle: latch demand and period together, so a mid-cycle change waits
  always_comb begin
    duty_nxt = duty_r;
    period_nxt = period_r;
    if (period_done) begin
      duty_nxt = sc.power_pm; // (R14) (R2)
      period_nxt = period_c; // (R5) (R7)
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      duty_r <= 10'h000;
      period_r <= PERIOD_RESET;
    end else begin
      duty_r <= duty_nxt;
      period_r <= period_nxt;
    end
  end

  // Position and on time in clock cycles; 64-bit product, longest period fits 32
  always_comb begin
    elapsed = 32'(tenth_r) * 32'(TICKS_PER_TENTH) + 32'(tick_r);
    on_ticks = 32'((64'(period_r) * 64'(duty_r) * 64'(TICKS_PER_TENTH)) / 64'd1000); // (R1)
  end

  // Line-cycle pacing: one decision at the end of every run of three cycles
  assign run_end = line_cycle_in && (run_r == LINE_MIN_RUN - 2'h1);

  always_comb begin
    run_nxt = run_r;
    if (run_end) begin
      run_nxt = 2'h0;
    end else if (line_cycle_in) begin
      run_nxt = run_r + 2'h1; // (R3)
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_r <= 2'h0;
    end else begin
      run_r <= run_nxt;
    end
  end

  // Error accumulator spreads on runs evenly; demand sampled once per run
  always_comb begin
    acc_add = acc_r + 13'(sc.power_pm);
    acc_nxt = acc_r;
    line_on_nxt = line_on_r;
    if (run_end) begin
      if (acc_add >= 13'(PERMILLE_FULL)) begin // (R14)
        line_on_nxt = 1'b1;
        acc_nxt = acc_add - 13'(PERMILLE_FULL); // (R1) (R4)
      end else begin
        line_on_nxt = 1'b0;
        acc_nxt = acc_add;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r <= 13'h0000;
      line_on_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      line_on_r <= line_on_nxt;
    end
  end

  always_comb begin
    want_on = 1'b0;
    unique case (mode)
      ST_OFF: want_on = 1'b0;
      ST_ON: want_on = 1'b1;
      ST_PROP: begin
        if (method == METHOD_LINE) begin
          want_on = line_on_r; // (R3) (R13)
        end else begin
          want_on = elapsed < on_ticks; // (R1) (R2)
        end
      end
    endcase
    out_nxt = want_on;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign load_on_out = out_r;
  assign power_permille_out = sc.power_pm;
  assign period_used_out = period_r;
endmodule : time_proportioning_output

// *** tpo_pkg.sv ***
// Constants for the time-proportioning output driver.
// Assumes a 40 MHz system clock and a clean line-cycle pulse input.
package tpo_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TENTH_MS = 100;
  // Cycles in one tenth of a second, the period and scale resolution.
  localparam int TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
  localparam logic [9:0] PERMILLE_FULL = 10'h3E8;
  localparam logic [9:0] PERIOD_MIN_SSR = 10'h001;
  localparam logic [9:0] PERIOD_MIN_RELAY = 10'h032;
  localparam logic [9:0] PERIOD_MAX = 10'h258;
  localparam logic [6:0] DEMAND_FULL = 7'h64;
  localparam logic [1:0] LINE_MIN_RUN = 2'h3;
  localparam logic [9:0] PERIOD_RESET = 10'h064;
  typedef enum logic [0:0] {
    METHOD_FIXED = 1'b0,
    METHOD_LINE = 1'b1
  } method_e;
endpackage : tpo_pkg

// *** tpo_scale_if.sv ***
// Bundle between the driver and its scaling unit.
// Assumes one clock domain; all signals synchronous.
`timescale 1ns/1ps
interface tpo_scale_if;
  logic [6:0] demand;
  logic [9:0] floor_pm;
  logic [9:0] ceil_pm;
  logic [9:0] power_pm;
  modport driver (output demand, output floor_pm, output ceil_pm, input power_pm);
  modport scaler (input demand, input floor_pm, input ceil_pm, output power_pm);
endinterface : tpo_scale_if

// *** tpo_scaler.sv ***
// Scales a percent demand between floor and ceiling, in per-mille.
// Assumes settings already clamped to 0..1000.
`timescale 1ns/1ps
module tpo_scaler
  import tpo_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  tpo_scale_if.scaler sc
);
  logic [9:0] power_r;
  logic [9:0] power_nxt;
  logic signed [18:0] span;
  logic signed [18:0] interp;

  always_comb begin
    span = 19'(signed'({1'b0, sc.ceil_pm})) - 19'(signed'({1'b0, sc.floor_pm}));
    // Linear between floor and ceiling; ceiling may sit below floor
    interp = 19'(signed'({1'b0, sc.floor_pm}))
           + 19'((span * 19'(signed'({1'b0, sc.demand}))) / 19'sd100); // (R11)
    if (sc.demand == 7'h00) begin
      power_nxt = sc.floor_pm; // (R9)
    end else if (sc.demand >= DEMAND_FULL) begin
      power_nxt = sc.ceil_pm; // (R10)
    end else begin
      power_nxt = interp[9:0];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_r <= 10'h000;
    end else begin
      power_r <= power_nxt;
    end
  end

  assign sc.power_pm = power_r;
endmodule : tpo_scaler

// *** tpo_properties.sv ***
// Port checker for the output driver, bound to every instance.
// Assumes the ceiling is never set below the floor.
`timescale 1ns/1ps
module tpo_properties
  import tpo_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic demand_is_digital_in,
  input wire logic demand_digital_in,
  input wire logic [6:0] demand_pct_in,
  input wire logic [9:0] floor_permille_in,
  input wire logic [9:0] ceil_permille_in,
  input wire logic load_on_out,
  input wire logic [9:0] power_permille_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  function automatic int lim(int v, int m);
    return v > m ? m : v;
  endfunction : lim
  function automatic int sc(int p, int f, int c);
    return lim(f, 1000) + (lim(c, 1000) - lim(f, 1000)) * lim(p, 100) / 100;
  endfunction : sc
  interp_power_a: assert property (!demand_is_digital_in |=> power_permille_out ==
    sc($past(demand_pct_in), $past(floor_permille_in), $past(ceil_permille_in)))
    else $error("scaled power off");
  floor_map_a: assert property (!demand_is_digital_in && demand_pct_in == 7'h00
    |=> power_permille_out == lim($past(floor_permille_in), 1000)) else $error("floor missed");
  ceil_map_a: assert property (!demand_is_digital_in && demand_pct_in >= 7'h64
    |=> power_permille_out == lim($past(ceil_permille_in), 1000)) else $error("ceiling missed");
  power_cap_a: assert property (power_permille_out <= PERMILLE_FULL)
    else $error("power above full");
  // Digital levels go through the scale, so full on needs a full ceiling
  digital_on_a: assert property ((demand_is_digital_in && demand_digital_in
    && ceil_permille_in >= 10'h3E8) [*3] |-> load_on_out) else $error("digital on ignored");
  digital_off_a: assert property ((demand_is_digital_in && !demand_digital_in
    && floor_permille_in == 10'h000) [*3] |-> !load_on_out) else $error("digital off ignored");
  // Forced states need two edges: power first, then the switch
  full_on_a: assert property ((!demand_is_digital_in && power_permille_out == 10'h3E8) [*2]
    |-> load_on_out) else $error("full power not on");
  zero_off_a: assert property ((!demand_is_digital_in && power_permille_out == 10'h000) [*2]
    |-> !load_on_out) else $error("zero power not off");
endmodule : tpo_properties
bind time_proportioning_output tpo_properties chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .demand_is_digital_in(demand_is_digital_in), .demand_digital_in(demand_digital_in),
  .demand_pct_in(demand_pct_in), .floor_permille_in(floor_permille_in),
  .ceil_permille_in(ceil_permille_in), .load_on_out(load_on_out),
  .power_permille_out(power_permille_out));

// *** ac_load_model.sv ***
// Load model: ac line reference pulses and a tally of energised line cycles.
// Assumes line cycles far shorter than real ones, to keep runs brief.
`timescale 1ns/1ps
module ac_load_model #(
  parameter int LINE_CLKS = 20
)
(
  input wire logic clock_in,
  input wire logic load_on_in,
  output logic line_pulse_out,
  output int on_cycles_out
);
  int div_r = 0;
  initial line_pulse_out = 1'b0;
  initial on_cycles_out = 0;
  always @(posedge clock_in) begin
    div_r <= div_r == LINE_CLKS - 1 ? 0 : div_r + 1;
    line_pulse_out <= #1 div_r == 0;
    if (div_r == 0 && load_on_in === 1'b1) on_cycles_out <= on_cycles_out + 1;
  end
endmodule : ac_load_model

// *** tb.sv ***
// Bench: demand scaling, forced on/off, line-cycle pacing, relay variant.
// Assumes the load model's 20-clock line cycle.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dig = 1'b0;
  logic don = 1'b0;
  logic lm = 1'b0;
  logic [9:0] pu;
  int ron = 0, lon = 0, rbase;
  logic [6:0] pct = 7'h00;
  logic [9:0] per = 10'h064;
  logic [9:0] flo = 10'h000;
  logic [9:0] cei = 10'h000;
  logic pulse, load, rload;
  logic [9:0] pw;
  int on_c, a, b, cyc = 0, miscompares = 0, samples_checked = 0;
  initial forever #12.5 clk = ~clk;
  ac_load_model lmod (.clock_in(clk), .load_on_in(load), .line_pulse_out(pulse),
    .on_cycles_out(on_c));
  // Short timebase: one tenth is 4 clocks, so fixed periods fit the run
  time_proportioning_output #(.TICKS_PER_TENTH(4)) dut (.clock_in(clk), .rst_n_in(rst_n),
    .demand_is_digital_in(dig), .demand_digital_in(don), .demand_pct_in(pct),
    .method_line_in(lm), .period_tenths_in(per), .floor_permille_in(flo),
    .ceil_permille_in(cei), .line_cycle_in(pulse), .load_on_out(load),
    .power_permille_out(pw), .period_used_out(pu));
  time_proportioning_output #(.RELAY_VARIANT(1'b1)) dut_relay (.clock_in(clk),
    .rst_n_in(rst_n), .demand_is_digital_in(dig), .demand_digital_in(don),
    .demand_pct_in(pct), .method_line_in(lm), .period_tenths_in(per),
    .floor_permille_in(flo), .ceil_permille_in(cei), .line_cycle_in(pulse),
    .load_on_out(rload), .power_permille_out(), .period_used_out());
  always @(posedge clk) begin
    if (rload === 1'b1) ron++;
    if (load === 1'b1) lon++;
  end
  function automatic int want(int p, int f, int c);
    f = f > 1000 ? 1000 : f;
    c = c > 1000 ? 1000 : c;
    return f + (c - f) * (p > 100 ? 100 : p) / 100;
  endfunction : want
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic drive(int d, int o, int p, int f, int c);
    @(posedge clk);
    #1;
    {dig, don, pct, flo, cei} = {1'(d), 1'(o), 7'(p), 10'(f), 10'(c)};
    per = 10'($urandom_range(1023));
  endtask : drive
  // Settle first: a new level only lands on a three-cycle boundary
  task automatic line_run(int pm);
    drive(0, 0, $urandom_range(100), pm, pm);
    repeat (240) @(posedge clk);
    a = on_c;
    repeat (1080) @(posedge clk);
    a = on_c - a;
    b = pm * 54 / 1000;
    chk(a > b + 4 || a + 4 < b ? a : b, b);
  endtask : line_run
  task automatic give_verdict();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(63465));
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 40; i++) begin
      a = $urandom_range(1100);
      b = a + $urandom_range(200);
      drive(0, 0, i < 4 ? i[0] * 100 : $urandom_range(110), a, b > 1023 ? 1023 : b);
      @(posedge clk);
      #1 chk(pw, want(pct, flo, cei));
    end
    for (int i = 3; i >= 0; i--) begin
      drive(i < 2, i[0], i[0] * 100, 0, 1000);
      repeat (3) @(posedge clk);
      #1 chk(load, i[0]);
      chk(rload, i[0]);
    end
    // Fixed period: 0 tenths clamps to 1 at 75 %, then 10 tenths at 40 %
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      #1 pct = i ? 7'h28 : 7'h4B;
      per = i ? 10'h00A : 10'h000;
      flo = 10'h000;
      cei = 10'h3E8;
      dig = 1'b0;
      repeat (2500) @(posedge clk);
      #1 chk(pu, i ? 10 : 1);
      a = lon;
      repeat (400) @(posedge clk);
      #1 chk(lon - a, 400 * (i ? 40 : 75) / 100);
    end
    lm = 1'b1;
    rbase = ron;
    line_run(500);
    chk(ron - rbase, 0);
    line_run(666);
    line_run($urandom_range(1000));
    line_run(0);
    line_run(1000);
    give_verdict();
  end
endmodule : tb
